// ### design/acc_ctrl.sv
// converter control: enable, start, scan select, done flag, irq, data-available
// assumes the converter core returns per-channel result strobes and a batch end
//
// Summary of operation
// - enable bit 7 switches; toggle re-arms
// - start bit 0 write begins conversion
// - control bit 6 selects scanning mode
// - non-scan converts one or several channels
// - done flag bit 4 set at completion
// - interrupt only when bit 3 set
// - per-channel data-available flags kept
`timescale 1ns/1ns
module acc_ctrl #(
    parameter int unsigned NCH = acc_pkg::NUM_CHAN
) (
    input  wire logic           sys_clk,
    input  wire logic           rst_n,
    input  wire logic           ctrl_wr,
    input  wire logic [7:0]     ctrl_wdata,
    input  wire logic           start_wr,
    input  wire logic [7:0]     start_wdata,
    input  wire logic [NCH-1:0] chan_sel,
    input  wire logic [NCH-1:0] avail_clr,
    input  wire logic [NCH-1:0] core_result,
    input  wire logic           core_end,
    output logic [7:0]          ctrl_rdata_q,
    output logic [7:0]          start_rdata_q,
    output logic [NCH-1:0]      avail_q,
    output logic                conv_go_q,
    output logic                conv_scan_q,
    output logic [NCH-1:0]      conv_chan_q,
    output logic                irq_q
);
    import acc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        acc_state_t     st;
        logic [7:0]     ctrl;
        logic           start;
        logic           go;
        logic           scan;
        logic [NCH-1:0] chan;
        logic           irq;
    } acc_state_all_t;

    acc_state_all_t s_q;
    acc_state_all_t s_d;
    logic           done_evt;
    logic           start_req;
    logic           in_idle;
    logic           in_conv;

    assign start_req = start_wr && start_wdata[START_BIT];
    assign in_idle   = (s_q.st == ACC_IDLE);
    assign in_conv   = (s_q.st == ACC_CONV);
    assign done_evt  = in_conv && core_end;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d     = s_q;
        s_d.go  = 1'b0;
        s_d.irq = 1'b0;
        if (ctrl_wr) begin
            // done bit is hardware owned; writing zero clears it
            s_d.ctrl = ctrl_wdata;
            s_d.ctrl[CTRL_DONE_BIT] = s_q.ctrl[CTRL_DONE_BIT] & ctrl_wdata[CTRL_DONE_BIT];
        end
        case (s_q.st)
            ACC_IDLE: begin
                if (start_req && s_q.ctrl[CTRL_EN_BIT]) begin
                    s_d.start = 1'b1;
                    s_d.go    = 1'b1;
                    s_d.scan  = s_q.ctrl[CTRL_SCAN_BIT];
                    s_d.chan  = chan_sel;
                    s_d.st    = ACC_CONV;
                end
            end
            ACC_CONV: begin
                if (core_end) begin
                    s_d.st = ACC_DONE;
                    s_d.ctrl[CTRL_DONE_BIT] = 1'b1;
                    s_d.start = 1'b0;
                    s_d.irq = s_q.ctrl[CTRL_IRQ_BIT];
                end
            end
            ACC_DONE: begin
                // one idle cycle lets the core drop its end strobe
                s_d.st = ACC_IDLE;
            end
            default: begin
                s_d.st = ACC_IDLE;
            end
        endcase
        if (!s_d.ctrl[CTRL_EN_BIT]) begin
            s_d.start = 1'b0;
            // a start met by a same-cycle disable never reaches the core
            s_d.go    = 1'b0;
            if (s_d.st == ACC_CONV) begin
                s_d.st = ACC_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q      <= '0;
            s_q.st   <= ACC_IDLE;
            s_q.ctrl <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per-channel available flags
    for (genvar i = 0; i < NCH; i++) begin : g_avail
        acc_chan_flag u_flag (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .set_i   (core_result[i] && in_conv),
            .clr_i   (avail_clr[i]),
            .flag_q  (avail_q[i])
        );
    end

    assign ctrl_rdata_q  = s_q.ctrl;
    assign start_rdata_q = {7'h00, s_q.start};
    assign conv_go_q     = s_q.go;
    assign conv_scan_q   = s_q.scan;
    assign conv_chan_q   = s_q.chan;
    assign irq_q         = s_q.irq;

    ////////////////////////////////////////////////////////////////////
    // start self-clear, done, irq, go, scan, chan and avail checks
    a_start_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_n) done_evt |=> !start_rdata_q[START_BIT])
        else $error("start not cleared");
    a_start_holds: assert property (
        @(posedge sys_clk) disable iff (!rst_n) start_rdata_q[START_BIT] && !core_end
        && !(ctrl_wr && !ctrl_wdata[CTRL_EN_BIT]) |=> start_rdata_q[START_BIT])
        else $error("start dropped early");
    a_done_sets: assert property (
        @(posedge sys_clk) disable iff (!rst_n) done_evt |=> ctrl_rdata_q[CTRL_DONE_BIT])
        else $error("done not set");
    a_done_source: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(ctrl_rdata_q[CTRL_DONE_BIT]) |-> $past(done_evt))
        else $error("done set without completion");
    a_done_holds: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ctrl_rdata_q[CTRL_DONE_BIT] && !ctrl_wr |=> ctrl_rdata_q[CTRL_DONE_BIT])
        else $error("done lost");
    a_irq_gated: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        irq_q |-> $past(done_evt) && $past(ctrl_rdata_q[CTRL_IRQ_BIT]))
        else $error("bad irq");
    a_irq_fires: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        done_evt && ctrl_rdata_q[CTRL_IRQ_BIT] |=> irq_q)
        else $error("irq missing");
    a_irq_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_n) irq_q |=> !irq_q)
        else $error("irq too long");
    a_go_enabled: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        conv_go_q |-> $past(ctrl_rdata_q[CTRL_EN_BIT]) && $past(start_req))
        else $error("bad go");
    a_off_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !ctrl_rdata_q[CTRL_EN_BIT] |-> !start_rdata_q[START_BIT] && !conv_go_q)
        else $error("busy while disabled");
    a_go_sets_start: assert property (
        @(posedge sys_clk) disable iff (!rst_n) conv_go_q |-> start_rdata_q[START_BIT])
        else $error("start low");
    a_go_pulse: assert property (
        @(posedge sys_clk) disable iff (!rst_n) conv_go_q |=> !conv_go_q)
        else $error("go too long");
    a_busy_refuses: assert property (
        @(posedge sys_clk) disable iff (!rst_n) start_req && !in_idle |=> !conv_go_q)
        else $error("start taken while busy");
    a_scan_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        conv_go_q |-> conv_scan_q == $past(ctrl_rdata_q[CTRL_SCAN_BIT]))
        else $error("scan");
    a_scan_steady: assert property (
        @(posedge sys_clk) disable iff (!rst_n) in_conv && !conv_go_q |-> $stable(conv_scan_q))
        else $error("scan changed mid batch");
    a_chan_latch: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        conv_go_q |-> conv_chan_q == $past(chan_sel))
        else $error("chan");
    a_avail_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n) in_conv && core_result[0] |=> avail_q[0])
        else $error("avail");
    a_avail_source: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(avail_q[0]) |-> $past(core_result[0]) && $past(in_conv))
        else $error("avail set without result");
    c_scan_run: cover property (@(posedge sys_clk) conv_go_q && conv_scan_q);
    c_single_run: cover property (@(posedge sys_clk) conv_go_q && !conv_scan_q);
    c_irq: cover property (@(posedge sys_clk) irq_q);
    c_abort: cover property (@(posedge sys_clk)
        $fell(start_rdata_q[START_BIT]) && !ctrl_rdata_q[CTRL_EN_BIT]);
endmodule // acc_ctrl

// ### design/acc_pkg.sv
// constants for the converter control block
// assumes one 20 MHz system clock and a converter core outside
package acc_pkg;
    localparam int unsigned CTRL_EN_BIT   = 7;
    localparam int unsigned CTRL_SCAN_BIT = 6;
    localparam int unsigned CTRL_DONE_BIT = 4;
    localparam int unsigned CTRL_IRQ_BIT  = 3;
    localparam int unsigned START_BIT     = 0;
    localparam int unsigned NUM_CHAN      = 8;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  AVAIL_RESET   = 8'h00;
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_DONE = 2'b10
    } acc_state_t;
endpackage

// ### design/acc_chan_flag.sv
// one sticky data-available flag for one channel
// assumes software clear and core update are one-cycle pulses
`timescale 1ns/1ns
module acc_chan_flag (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_q
);
    typedef struct packed {
        logic flag;
    } acc_flag_state_t;
    acc_flag_state_t s_q;
    acc_flag_state_t s_d;
    always_comb begin
        s_d = s_q;
        // set wins over a same-cycle clear
        if (clr_i) begin
            s_d.flag = 1'b0;
        end
        if (set_i) begin
            s_d.flag = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign flag_q = s_q.flag;
endmodule // acc_chan_flag

// ### bench/acc_core_model.sv
// converter core stand-in: answers each go with channel results and batch end together in one cycle, DLY cycles after sampling go
// assumes go and chan come from acc_ctrl on the same sys_clk
`timescale 1ns/1ns
module acc_core_model #(
    parameter int DLY = 5
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [7:0] chan,
    output logic [7:0]      result,
    output logic            done
);
    int cnt;
    // pulses only, so nothing is left standing between batches
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            result <= 8'h00;
            done <= 1'b0;
        end else begin
            result <= (cnt == 1) ? chan : 8'h00;
            done <= (cnt == 1);
            cnt <= go ? DLY : ((cnt > 0) ? cnt - 1 : 0);
        end
    end
endmodule // acc_core_model

// ### bench/tb.sv
// self-checking bench for acc_ctrl with a core stand-in
// assumes 20 MHz sys_clk and eight channels
`timescale 1ns/1ns
module tb;
    import acc_pkg::*;
    logic       sys_clk = 0, rst_n = 0, ctrl_wr = 0, start_wr = 0;
    logic [7:0] ctrl_wdata = 0, start_wdata = 0, chan_sel = 0, avail_clr = 0, m;
    logic [7:0] ctrl_rdata_q, start_rdata_q, avail_q, conv_chan_q, core_result;
    logic       core_end, conv_go_q, conv_scan_q, irq_q;
    int         err_count = 0, n_compared = 0, irq_cnt = 0, go_cnt = 0;
    int         irq_base, go_base, i, j, k;
    always #25 sys_clk = ~sys_clk;
    // one-cycle pulses: a falling edge inside each counts it exactly once
    always @(negedge sys_clk) if (irq_q === 1'b1) irq_cnt++;
    always @(negedge sys_clk) if (conv_go_q === 1'b1) go_cnt++;
    acc_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .start_wr(start_wr), .start_wdata(start_wdata),
        .chan_sel(chan_sel), .avail_clr(avail_clr), .core_result(core_result),
        .core_end(core_end), .ctrl_rdata_q(ctrl_rdata_q), .start_rdata_q(start_rdata_q),
        .avail_q(avail_q), .conv_go_q(conv_go_q), .conv_scan_q(conv_scan_q),
        .conv_chan_q(conv_chan_q), .irq_q(irq_q));
    acc_core_model core (.sys_clk(sys_clk), .rst_n(rst_n), .go(conv_go_q),
        .chan(conv_chan_q), .result(core_result), .done(core_end));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wctrl(input logic [7:0] v);
        @(negedge sys_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = v;
        @(negedge sys_clk);
        ctrl_wr = 1'b0;
    endtask
    task wstart(input logic [7:0] v);
        @(negedge sys_clk);
        start_wr = 1'b1;
        start_wdata = v;
        @(negedge sys_clk);
        start_wr = 1'b0;
    endtask
    task summarize;
        if (err_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        chk(ctrl_rdata_q, CTRL_RESET);
        chk(avail_q, AVAIL_RESET);
        wstart(8'h01);
        @(negedge sys_clk);
        chk(start_rdata_q, 8'h00);
        k = go_cnt;
        chk(k[7:0], 8'h00);
        // all four scan and irq-enable combinations, single and several channels
        for (i = 0; i < 4; i++) begin
            m = {2'b10, 6'h00} | {1'b0, i[1], 2'b00, i[0], 3'b000};
            chan_sel = i[0] ? 8'h01 : 8'hB6;
            wctrl(8'h00);
            wctrl(m);
            chk(ctrl_rdata_q, m);
            irq_base = irq_cnt;
            go_base = go_cnt;
            wstart(8'h01);
            @(negedge sys_clk);
            chk(start_rdata_q, 8'h01);
            chk({7'h00, conv_scan_q}, {7'h00, m[6]});
            chk(conv_chan_q, chan_sel);
            // a second start while the batch runs must be dropped
            wstart(8'h01);
            for (j = 0; j < 50 && ctrl_rdata_q[4] !== 1'b1; j++) @(negedge sys_clk);
            repeat (2) @(negedge sys_clk);
            chk(ctrl_rdata_q, m | 8'h10);
            chk(start_rdata_q, 8'h00);
            k = irq_cnt - irq_base;
            chk(k[7:0], {7'h00, m[3]});
            k = go_cnt - go_base;
            chk(k[7:0], 8'h01);
            chk(avail_q, chan_sel);
            avail_clr = chan_sel;
            @(negedge sys_clk);
            avail_clr = 8'h00;
            @(negedge sys_clk);
            chk(avail_q, 8'h00);
        end
        // clearing enable mid-batch drops it: no done, no irq, no marks
        wctrl(8'h00);
        wctrl(8'h88);
        irq_base = irq_cnt;
        go_base = go_cnt;
        wstart(8'h01);
        wctrl(8'h08);
        repeat (10) @(negedge sys_clk);
        chk(start_rdata_q, 8'h00);
        chk(ctrl_rdata_q, 8'h08);
        chk(avail_q, 8'h00);
        k = irq_cnt - irq_base;
        chk(k[7:0], 8'h00);
        k = go_cnt - go_base;
        chk(k[7:0], 8'h01);
        summarize;
    end
    // the whole run needs well under 600 cycles
    initial begin
        #(2000 * 50);
        err_count++;
        summarize;
    end
endmodule // tb
